// ---- rtl/smx_pkg.sv ----
// constants and types shared by the card-slot multiplexer register bank
package smx_pkg;
	// =====================================================================
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int TICK_HZ = 32_768;
	// debounce tick period in clock cycles, rounded down
	localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
	localparam logic [10:0] TICK_LAST = 11'(TICK_CYCLES - 1);

	// =====================================================================
	// register offsets
	localparam logic [7:0] OFS_HW_ID = 8'h00;
	localparam logic [7:0] OFS_DRV_VER = 8'h01;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SLOT_CTRL = 8'h08;
	localparam logic [7:0] OFS_BSI_DB = 8'h0a;
	localparam logic [7:0] OFS_SDN_DB = 8'h0b;
	localparam logic [7:0] OFS_RSVD = 8'h0c;
	localparam logic [7:0] OFS_CLK_SRC = 8'h0d;
	localparam logic [7:0] OFS_DEV_CTRL = 8'h0e;
	localparam logic [7:0] OFS_TEST_FIRST = 8'h10;
	localparam logic [7:0] OFS_TEST_LAST = 8'h14;
	localparam logic [7:0] OFS_GP = 8'h15;

	// =====================================================================
	// reset values
	localparam logic [7:0] RST_DRV_VER = 8'h00;
	localparam logic [7:0] RST_DEBOUNCE = 8'h04;
	localparam logic [7:0] RST_ZERO = 8'h00;

	// =====================================================================
	// status and slot control field positions
	localparam int ST_SDN_LVL = 0;
	localparam int ST_SDN_IRQ = 1;
	localparam int ST_BAT_ABS = 2;
	localparam int ST_BAT_IRQ = 3;
	localparam int CTL_SLOT1_EN = 0;
	localparam int CTL_SLOT1_STATE = 2;
	localparam int CTL_SLOT2_EN = 4;
	localparam int CTL_SLOT2_STATE = 6;
	localparam logic [1:0] SLOT_DOWN = 2'h0;
	localparam logic [1:0] SLOT_POWERED = 2'h2;

	// =====================================================================
	// serial control bus
	localparam logic [6:0] BUS_ADDR_IRQ_LOW = 7'h3a;
	localparam logic [6:0] BUS_ADDR_IRQ_HIGH = 7'h3b;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0] {
		SMX_IDLE, SMX_ADDR, SMX_ACK_ADDR, SMX_PTR, SMX_ACK_PTR,
		SMX_WDATA, SMX_ACK_WDATA, SMX_RDATA, SMX_RACK
	} smx_bus_state_t;
endpackage : smx_pkg

// ---- rtl/smx_evt_if.sv ----
// carrier between the register bank and one input debouncer
`timescale 1ns/1ps
`default_nettype none
interface smx_evt_if;
	logic raw;
	logic [7:0] limit;
	logic level;
	logic change;
	// debouncer side
	modport src (input raw, input limit, output level, output change);
	// register bank side
	modport dst (output raw, output limit, input level, input change);
endinterface : smx_evt_if
`default_nettype wire

// ---- rtl/smx_sync.sv ----
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module smx_sync #(
	parameter int WIDTH = 5
) (
	input wire logic clock, // system clock
	input wire logic [WIDTH-1:0] din, // asynchronous pin levels
	output logic [WIDTH-1:0] dout // synchronised levels
);
	// =====================================================================
	// per-bit stages; no reset so a strap level is seen during reset
	logic [WIDTH-1:0] meta;
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge clock) begin
			meta[i] <= din[i];
			dout[i] <= meta[i];
		end
	end
endmodule : smx_sync
`default_nettype wire

// ---- rtl/smx_debounce.sv ----
// debounce counter for one detection input, stepped by the slow tick
`timescale 1ns/1ps
`default_nettype none
module smx_debounce (
	input wire logic clock, // system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic tick, // one-cycle slow tick
	smx_evt_if.src ev // raw level in, debounced level out
);
	logic [7:0] cnt;

	// =====================================================================
	// level follows raw only after limit+1 ticks of disagreement
	always_ff @(posedge clock) begin
		if (srst) begin
			cnt <= 8'h00;
			ev.level <= 1'b0;
			ev.change <= 1'b0;
		end else begin
			ev.change <= 1'b0;
			if (ev.raw == ev.level) begin
				cnt <= 8'h00; // glitch shorter than the window is dropped
			end else if (tick) begin
				if (cnt >= ev.limit) begin
					ev.level <= ev.raw;
					ev.change <= 1'b1;
					cnt <= 8'h00;
				end else begin
					cnt <= cnt + 8'h01;
				end
			end
		end
	end
endmodule : smx_debounce
`default_nettype wire

// ---- rtl/smx_register_bank.sv ----
// register bank of the dual card-slot multiplexer behind its serial control bus
`timescale 1ns/1ps
`default_nettype none
module smx_register_bank #(
	parameter logic [3:0] MAKER_CODE = 4'h5, // arbitrary value
	parameter logic [3:0] DEVICE_CODE = 4'ha, // arbitrary value
	parameter int TEST_REGS = 5
) (
	input wire logic clock, // 50 MHz system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic scl_in, // bus clock pin
	input wire logic sda_in, // bus data pin level
	output logic sda_out, // bus data drive value, always low
	output logic sda_oe, // high pulls bus data low
	input wire logic irq_in, // interrupt pin level, strap at reset
	output logic irq_out, // interrupt drive value, always low
	output logic irq_oe, // high pulls interrupt pin low
	input wire logic shutdown_input, // shutdown pin
	input wire logic battery_sense_input, // battery comparator, high = present
	output logic [7:0] slot_control // interface control register contents
);
	// =====================================================================
	// pin synchronisers
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_IRQ = 2;
	localparam int PIN_SDN = 3;
	localparam int PIN_BSI = 4;

	logic [4:0] pins_s;
	smx_sync #(.WIDTH(5)) u_sync (
		.clock(clock),
		.din({battery_sense_input, shutdown_input, irq_in, sda_in, scl_in}),
		.dout(pins_s)
	);

	// =====================================================================
	// bus edge and condition detection on the synchronised copies
	logic scl_d;
	logic sda_d;
	always_ff @(posedge clock) begin
		if (srst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= pins_s[PIN_SCL];
			sda_d <= pins_s[PIN_SDA];
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise = pins_s[PIN_SCL] & ~scl_d;
	assign scl_fall = ~pins_s[PIN_SCL] & scl_d;
	assign bus_start = pins_s[PIN_SCL] & scl_d & sda_d & ~pins_s[PIN_SDA];
	assign bus_stop = pins_s[PIN_SCL] & scl_d & ~sda_d & pins_s[PIN_SDA];

	// =====================================================================
	// bus address strap
	// strap sets address
	// the pin is caught while reset is held, before this end drives it
	logic addr_strap;
	always_ff @(posedge clock) begin
		if (srst) begin
			addr_strap <= pins_s[PIN_IRQ];
		end
	end

	logic [6:0] dev_addr;
	assign dev_addr = addr_strap ? smx_pkg::BUS_ADDR_IRQ_HIGH : smx_pkg::BUS_ADDR_IRQ_LOW;

	// =====================================================================
	// slow tick for the debounce counters
	logic [10:0] tick_cnt;
	logic tick;
	always_ff @(posedge clock) begin
		if (srst) begin
			tick_cnt <= 11'h000;
			tick <= 1'b0;
		end else if (tick_cnt == smx_pkg::TICK_LAST) begin
			tick_cnt <= 11'h000;
			tick <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 11'h001;
			tick <= 1'b0;
		end
	end

	// =====================================================================
	// software-written registers
	logic [7:0] bsi_db;
	logic [7:0] sdn_db;
	logic [7:0] clk_src;
	logic [7:0] dev_ctrl;
	logic [7:0] gp_reg;
	logic [7:0] test_reg [TEST_REGS];

	// =====================================================================
	// input debouncers
	smx_evt_if sdn_if ();
	smx_evt_if bat_if ();
	assign sdn_if.raw = pins_s[PIN_SDN];
	assign sdn_if.limit = sdn_db;
	assign bat_if.raw = ~pins_s[PIN_BSI];
	assign bat_if.limit = bsi_db;

	smx_debounce u_sdn_db (
		.clock(clock),
		.srst(srst),
		.tick(tick),
		.ev(sdn_if)
	);
	smx_debounce u_bat_db (
		.clock(clock),
		.srst(srst),
		.tick(tick),
		.ev(bat_if)
	);

	// =====================================================================
	// bus byte engine state
	smx_pkg::smx_bus_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] tx_sh;
	logic [7:0] ptr;
	logic rw;
	logic master_ack;
	logic byte_done;
	assign byte_done = (bit_cnt == smx_pkg::BITS_PER_BYTE);

	// a read byte is fetched on the falling edge that ends an acknowledge
	logic load_tx;
	assign load_tx = scl_fall && !bus_start && !bus_stop &&
		((state == smx_pkg::SMX_ACK_ADDR && rw) || (state == smx_pkg::SMX_RACK && master_ack));

	logic wr_now;
	assign wr_now = scl_fall && !bus_start && !bus_stop && state == smx_pkg::SMX_WDATA && byte_done;

	// =====================================================================
	// interrupt flags and slot status
	logic sdn_irq;
	logic bat_irq;
	logic status_clr;
	assign status_clr = load_tx && (ptr == smx_pkg::OFS_STATUS);

	always_ff @(posedge clock) begin
		if (srst) begin
			sdn_irq <= 1'b0;
		end else begin
			sdn_irq <= sdn_if.change | (sdn_irq & ~status_clr);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			bat_irq <= 1'b0;
		end else begin
			bat_irq <= (bat_if.change & bat_if.level) | (bat_irq & ~status_clr);
		end
	end

	// slot status mapping
	// reserved state 00 with regulator on reads as powered, as the table allows
	function automatic logic [1:0] slot_status(input logic reg_en, input logic [1:0] if_state);
		logic [1:0] code;
		code = smx_pkg::SLOT_DOWN;
		if (reg_en) begin
			code = (if_state == 2'h0) ? smx_pkg::SLOT_POWERED : if_state;
		end
		return code;
	endfunction : slot_status

	logic [7:0] status_val;
	always_comb begin
		status_val = 8'h00;
		status_val[smx_pkg::ST_SDN_LVL] = pins_s[PIN_SDN];
		status_val[smx_pkg::ST_SDN_IRQ] = sdn_irq;
		status_val[smx_pkg::ST_BAT_ABS] = bat_if.level;
		status_val[smx_pkg::ST_BAT_IRQ] = bat_irq;
		status_val[5:4] = slot_status(slot_control[smx_pkg::CTL_SLOT1_EN],
			slot_control[smx_pkg::CTL_SLOT1_STATE +: 2]);
		status_val[7:6] = slot_status(slot_control[smx_pkg::CTL_SLOT2_EN],
			slot_control[smx_pkg::CTL_SLOT2_STATE +: 2]);
	end

	// =====================================================================
	// read multiplexer; unmapped and reserved offsets read zero
	logic [7:0] rd_val;
	logic [2:0] test_idx;
	assign test_idx = 3'(ptr - smx_pkg::OFS_TEST_FIRST);

	always_comb begin
		rd_val = 8'h00;
		unique case (ptr)
			smx_pkg::OFS_HW_ID: rd_val = {MAKER_CODE, DEVICE_CODE};
			smx_pkg::OFS_DRV_VER: rd_val = smx_pkg::RST_DRV_VER;
			smx_pkg::OFS_STATUS: rd_val = status_val;
			smx_pkg::OFS_SLOT_CTRL: rd_val = slot_control;
			smx_pkg::OFS_BSI_DB: rd_val = bsi_db;
			smx_pkg::OFS_SDN_DB: rd_val = sdn_db;
			smx_pkg::OFS_CLK_SRC: rd_val = clk_src;
			smx_pkg::OFS_DEV_CTRL: rd_val = dev_ctrl;
			smx_pkg::OFS_GP: rd_val = gp_reg;
			default: begin
				if (ptr >= smx_pkg::OFS_TEST_FIRST && ptr <= smx_pkg::OFS_TEST_LAST) begin
					rd_val = test_reg[test_idx];
				end
			end
		endcase
	end

	// =====================================================================
	// register writes, taken when the eighth data bit has been clocked
	always_ff @(posedge clock) begin
		if (srst) begin
			slot_control <= smx_pkg::RST_ZERO;
			bsi_db <= smx_pkg::RST_DEBOUNCE;
			sdn_db <= smx_pkg::RST_DEBOUNCE;
			clk_src <= smx_pkg::RST_ZERO;
			dev_ctrl <= smx_pkg::RST_ZERO;
			gp_reg <= smx_pkg::RST_ZERO;
		end else if (wr_now) begin
			unique case (ptr)
				smx_pkg::OFS_SLOT_CTRL: slot_control <= shreg;
				smx_pkg::OFS_BSI_DB: bsi_db <= shreg;
				smx_pkg::OFS_SDN_DB: sdn_db <= shreg;
				smx_pkg::OFS_CLK_SRC: clk_src <= shreg;
				smx_pkg::OFS_DEV_CTRL: dev_ctrl <= shreg;
				smx_pkg::OFS_GP: gp_reg <= shreg;
				default: ; // read-only or unmapped: write dropped; test bytes are stored below
			endcase
		end
	end

	// factory test bytes, plain storage
	for (genvar i = 0; i < TEST_REGS; i++) begin : g_test
		always_ff @(posedge clock) begin
			if (srst) begin
				test_reg[i] <= smx_pkg::RST_ZERO;
			end else if (wr_now && ptr == smx_pkg::OFS_TEST_FIRST + 8'(i)) begin
				test_reg[i] <= shreg;
			end
		end
	end

	// =====================================================================
	// bus byte engine: address, pointer, write data, read data
	// data changes only after scl falls, so setup to the next rise is a half period
	always_ff @(posedge clock) begin
		if (srst) begin
			state <= smx_pkg::SMX_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			tx_sh <= 8'h00;
			ptr <= 8'h00;
			rw <= 1'b0;
			master_ack <= 1'b0;
			sda_oe <= 1'b0;
		end else if (bus_start) begin
			state <= smx_pkg::SMX_ADDR;
			bit_cnt <= 4'h0;
			sda_oe <= 1'b0;
		end else if (bus_stop) begin
			state <= smx_pkg::SMX_IDLE;
			sda_oe <= 1'b0;
		end else if (scl_rise) begin
			if (state == smx_pkg::SMX_RACK) begin
				master_ack <= ~pins_s[PIN_SDA];
			end else if (state inside {smx_pkg::SMX_ADDR, smx_pkg::SMX_PTR, smx_pkg::SMX_WDATA}) begin
				shreg <= {shreg[6:0], pins_s[PIN_SDA]};
			end
			bit_cnt <= bit_cnt + 4'h1;
		end else if (scl_fall) begin
			unique case (state)
				smx_pkg::SMX_IDLE: ;
				smx_pkg::SMX_ADDR: begin
					if (byte_done) begin
						if (shreg[7:1] == dev_addr) begin
							state <= smx_pkg::SMX_ACK_ADDR;
							rw <= shreg[0];
							sda_oe <= 1'b1;
						end else begin
							state <= smx_pkg::SMX_IDLE; // another target, stay off the bus
						end
					end
				end
				smx_pkg::SMX_PTR: begin
					if (byte_done) begin
						ptr <= shreg;
						state <= smx_pkg::SMX_ACK_PTR;
						sda_oe <= 1'b1;
					end
				end
				smx_pkg::SMX_WDATA: begin
					if (byte_done) begin
						ptr <= ptr + 8'h01;
						state <= smx_pkg::SMX_ACK_WDATA;
						sda_oe <= 1'b1;
					end
				end
				smx_pkg::SMX_ACK_ADDR: begin
					bit_cnt <= 4'h0;
					if (rw) begin
						state <= smx_pkg::SMX_RDATA;
						tx_sh <= rd_val;
						sda_oe <= ~rd_val[7];
						ptr <= ptr + 8'h01;
					end else begin
						state <= smx_pkg::SMX_PTR;
						sda_oe <= 1'b0;
					end
				end
				smx_pkg::SMX_ACK_PTR, smx_pkg::SMX_ACK_WDATA: begin
					state <= smx_pkg::SMX_WDATA;
					bit_cnt <= 4'h0;
					sda_oe <= 1'b0;
				end
				smx_pkg::SMX_RDATA: begin
					if (byte_done) begin
						state <= smx_pkg::SMX_RACK;
						bit_cnt <= 4'h0;
						sda_oe <= 1'b0; // release for the master's acknowledge
					end else begin
						tx_sh <= {tx_sh[6:0], 1'b0};
						sda_oe <= ~tx_sh[6];
					end
				end
				smx_pkg::SMX_RACK: begin
					bit_cnt <= 4'h0;
					if (master_ack) begin
						state <= smx_pkg::SMX_RDATA;
						tx_sh <= rd_val;
						sda_oe <= ~rd_val[7];
						ptr <= ptr + 8'h01;
					end else begin
						state <= smx_pkg::SMX_IDLE;
					end
				end
			endcase
		end
	end

	// =====================================================================
	// open-drain pin drivers
	// interrupt pin pending
	// the pin is only pulled low, so the strap pull-up still decides idle level
	always_ff @(posedge clock) begin
		if (srst) begin
			irq_oe <= 1'b0;
			irq_out <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			irq_oe <= sdn_irq | bat_irq;
			irq_out <= 1'b0;
			sda_out <= 1'b0;
		end
	end
endmodule : smx_register_bank
`default_nettype wire

// ---- tb/smx_bank_assertions.sv ----
// port-level checker for the card-slot multiplexer register bank
`timescale 1ns/1ps
`default_nettype none
module smx_bank_assertions (
	input wire logic clock, // system clock
	input wire logic srst, // synchronous reset
	input wire logic scl_in, // bus clock pin
	input wire logic sda_out, // data drive value
	input wire logic sda_oe, // data pull enable
	input wire logic irq_out, // interrupt drive value
	input wire logic irq_oe, // interrupt pull enable
	input wire logic shutdown_input, // shutdown pin
	input wire logic battery_sense_input, // battery pin
	input wire logic [7:0] slot_control // control register
);
	localparam int MAX_WAIT = 400000; // longest debounce plus margin
	logic scl_q;
	logic [1:0] pins_q;
	logic [5:0] scl_idle;
	logic [18:0] pin_idle;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);
	// =====================================================
	// helper counters
	// cycles since the bus clock last moved, saturating
	always_ff @(posedge clock) begin
		scl_q <= scl_in;
		if (srst || scl_in != scl_q) scl_idle <= 6'h00;
		else if (scl_idle != 6'h3f) scl_idle <= scl_idle + 6'h01;
	end
	// cycles since either detection pin moved
	always_ff @(posedge clock) begin
		pins_q <= {shutdown_input, battery_sense_input};
		if (srst || pins_q != {shutdown_input, battery_sense_input}) pin_idle <= 19'h00000;
		else if (pin_idle != 19'h7ffff) pin_idle <= pin_idle + 19'h00001;
	end
	// =====================================================
	// properties
	// reset clears outputs
	reset_clear_a: assert property ($fell(srst) |-> !sda_oe && !irq_oe && slot_control == 8'h00)
		else $error("outputs not cleared by reset");
	pins_low_a: assert property (sda_out == 1'b0 && irq_out == 1'b0)
		else $error("open drain pin driven high");
	irq_clear_bus_a: assert property ($fell(irq_oe) |-> scl_idle < 6'd10)
		else $error("interrupt released without a bus read");
	irq_cause_a: assert property ($rose(irq_oe) |-> pin_idle >= 19'd3 && pin_idle < MAX_WAIT)
		else $error("interrupt raised with no pin change");
	slot_quiet_a: assert property ($changed(slot_control) |-> scl_idle < 6'd12)
		else $error("control register changed with bus idle");
	sda_move_low_a: assert property ($changed(sda_oe) |-> !scl_in && scl_idle <= 6'd7)
		else $error("data drive changed outside clock low");
	sda_after_high_a: assert property ($changed(sda_oe) |-> $past(scl_in, 5))
		else $error("data drive changed late in clock low");
	sda_idle_release_a: assert property (scl_in && scl_idle == 6'h3f |-> !sda_oe)
		else $error("data held low on idle bus");
endmodule : smx_bank_assertions
bind smx_register_bank smx_bank_assertions u_chk (.clock(clock), .srst(srst), .scl_in(scl_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .irq_out(irq_out), .irq_oe(irq_oe), .shutdown_input(shutdown_input),
	.battery_sense_input(battery_sense_input), .slot_control(slot_control));
`default_nettype wire

// ---- tb/smx_host_model.sv ----
// baseband host model mastering the serial control bus
`timescale 1ns/1ps
`default_nettype none
module smx_host_model #(
	parameter logic [6:0] DEV_ADDR = 7'h3b
) (
	input wire logic clock, // system clock
	input wire logic sda_line, // resolved bus data
	output logic scl, // bus clock, high at rest
	output logic sda_low // high pulls bus data low
);
	// bus at rest, released to the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// =====================================================
	// bus cycles, eight clocks per phase
	task automatic hp(input int n);
		repeat (n) @(negedge clock);
	endtask : hp
	// data moves two clocks after the fall so it never looks like a start or stop
	task automatic bitx(input logic b, output logic s);
		hp(2);
		sda_low = !b;
		hp(6);
		scl = 1'b1;
		hp(4);
		s = sda_line;
		hp(4);
		scl = 1'b0;
	endtask : bitx
	task automatic start;
		hp(2);
		sda_low = 1'b0;
		hp(6);
		scl = 1'b1;
		hp(8);
		sda_low = 1'b1;
		hp(8);
		scl = 1'b0;
	endtask : start
	task automatic stop;
		hp(2);
		sda_low = 1'b1;
		hp(6);
		scl = 1'b1;
		hp(8);
		sda_low = 1'b0;
		hp(8);
	endtask : stop
	// last high releases the ninth bit
	task automatic xbyte(input logic [7:0] w, input logic last, output logic [7:0] r, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
		bitx(last, s);
		ack = !s;
	endtask : xbyte
	task automatic probe(input logic [6:0] a, output logic ok);
		logic [7:0] r;
		start();
		xbyte({a, 1'b0}, 1'b1, r, ok);
		stop();
	endtask : probe
	task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2;
		start();
		xbyte({DEV_ADDR, 1'b0}, 1'b1, r, a0);
		xbyte(p, 1'b1, r, a1);
		xbyte(d, 1'b1, r, a2);
		stop();
		ok = a0 && a1 && a2;
	endtask : wr
	// pointer write, repeated start, one byte then no-ack
	task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2, a3;
		start();
		xbyte({DEV_ADDR, 1'b0}, 1'b1, r, a0);
		xbyte(p, 1'b1, r, a1);
		start();
		xbyte({DEV_ADDR, 1'b1}, 1'b1, r, a2);
		xbyte(8'hff, 1'b1, d, a3);
		stop();
		ok = a0 && a1 && a2;
	endtask : rd
endmodule : smx_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the card-slot multiplexer register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [7:0] HW_ID = 8'h5a; // arbitrary maker and device codes
	localparam logic [7:0] ST = smx_pkg::OFS_STATUS;
	localparam logic [7:0] OFS [11] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h15, 8'h20};
	localparam logic [7:0] RV [11] = '{HW_ID, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [10:0] RW = 11'h3b8; // entries that keep a write
	logic clock, srst, shutdown_input, battery_sense_input, scl, sda_low;
	logic sda_out, sda_oe, irq_out, irq_oe;
	logic [7:0] slot_control;
	wire logic sda_line = !(sda_oe || sda_low);
	wire logic irq_line = !irq_oe;
	int errors = 0;
	int total_checks = 0;
	int seed = 22;
	smx_register_bank #(.MAKER_CODE(HW_ID[7:4]), .DEVICE_CODE(HW_ID[3:0]), .TEST_REGS(5)) u_dut (
		.clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.irq_in(irq_line), .irq_out(irq_out), .irq_oe(irq_oe), .shutdown_input(shutdown_input),
		.battery_sense_input(battery_sense_input), .slot_control(slot_control));
	// pull-up on the interrupt pin straps the upper bus address
	smx_host_model #(.DEV_ADDR(smx_pkg::BUS_ADDR_IRQ_HIGH)) u_host (
		.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
	// 50 MHz clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// =====================================================
	// helpers
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic wrchk(input logic [7:0] p, input logic [7:0] d);
		logic ok;
		u_host.wr(p, d, ok);
		check("write ack", 8'h01, {7'h00, ok});
	endtask : wrchk
	task automatic rdchk(input logic [7:0] p, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		u_host.rd(p, d, ok);
		check("read ack", 8'h01, {7'h00, ok});
		check($sformatf("reg %h", p), exp, d);
	endtask : rdchk
	// slot status: regulator off reads powered down, state 00 reads powered
	function automatic logic [1:0] slot_st(input logic en, input logic [1:0] st);
		if (!en) return smx_pkg::SLOT_DOWN;
		return (st == 2'h0) ? smx_pkg::SLOT_POWERED : st;
	endfunction : slot_st
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	// bounded wait for the interrupt pin
	task automatic wait_irq;
		int n;
		n = 0;
		while (irq_oe !== 1'b1 && n < 20000) begin
			@(negedge clock);
			n++;
		end
		check("irq_oe", 8'h01, {7'h00, irq_oe});
		if (n == 20000) results();
	endtask : wait_irq
	// =====================================================
	// main sequence
	initial begin
		logic [7:0] c, r;
		logic [3:0] sl;
		logic ok;
		srst = 1'b1;
		shutdown_input = 1'b0;
		battery_sense_input = 1'b1;
		repeat (6) @(negedge clock);
		srst = 1'b0;
		repeat (4) @(negedge clock);
		u_host.probe(smx_pkg::BUS_ADDR_IRQ_LOW, ok);
		check("nak", 8'h00, {7'h00, ok});
		u_host.probe(smx_pkg::BUS_ADDR_IRQ_HIGH, ok);
		check("ack", 8'h01, {7'h00, ok});
		$display("test address done");
		// reset values, then a write to each place but the test bytes, one unmapped
		for (int i = 0; i < 11; i++) rdchk(OFS[i], RV[i]);
		for (int i = 0; i < 11; i++) begin
			r = 8'($random(seed));
			wrchk(OFS[i], r);
			rdchk(OFS[i], RW[i] ? r : RV[i]);
		end
		$display("test registers done");
		// every enable and state pair on both slots
		for (int k = 0; k < 16; k++) begin
			r = 8'($random(seed));
			c = {~k[1:0], r[5], k[3], k[1:0], r[1], k[2]};
			wrchk(smx_pkg::OFS_SLOT_CTRL, c);
			check("slot_control", c, slot_control);
			sl = {slot_st(c[4], c[7:6]), slot_st(c[0], c[3:2])};
			rdchk(ST, {sl, 4'h0});
		end
		$display("test slot status done");
		// level shows at once, the flag only after the debounce
		wrchk(smx_pkg::OFS_SDN_DB, smx_pkg::RST_DEBOUNCE);
		shutdown_input = 1'b1;
		repeat (10) @(negedge clock);
		rdchk(ST, {sl, 4'h1});
		wait_irq();
		rdchk(ST, {sl, 4'h3});
		rdchk(ST, {sl, 4'h1});
		check("irq_oe", 8'h00, {7'h00, irq_oe});
		$display("test shutdown done");
		wrchk(smx_pkg::OFS_BSI_DB, 8'h00);
		battery_sense_input = 1'b0;
		wait_irq();
		rdchk(ST, {sl, 4'hd});
		rdchk(ST, {sl, 4'h5});
		// restore raises no interrupt; limit 0 means one tick
		battery_sense_input = 1'b1;
		repeat (3 * smx_pkg::TICK_CYCLES) @(negedge clock);
		rdchk(ST, {sl, 4'h1});
		check("irq_oe", 8'h00, {7'h00, irq_oe});
		$display("test battery done");
		results();
	end
endmodule : tb_top
`default_nettype wire
